// ---- shared/isf_pkg.sv ----
// Constants and types shared by the status-flag block.
package isf_pkg;
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RXDATA = 8'h08;
   localparam logic [7:0] OFS_TXDATA = 8'h0c;
   localparam logic [7:0] OFS_EVSTAT = 8'h10;
   localparam logic [7:0] OFS_EVCLR  = 8'h14;
   localparam logic [7:0] OFS_EVEN   = 8'h18;
   localparam int CTRL_RUN     = 0;
   localparam int CTRL_START   = 1;
   localparam int CTRL_FREE    = 2;
   localparam int CTRL_OWN_LSB = 8;
   localparam int ST_BUSY      = 12;
   localparam int ST_OVR       = 11;
   localparam int ST_UND_N     = 10;
   localparam int ST_AAS       = 9;
   localparam int EV_START     = 0;
   localparam int EV_STOP      = 1;
   localparam int EV_OVR       = 2;
   localparam int EV_UND       = 3;
   localparam int EV_AAS       = 4;
   localparam int EV_W         = 5;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT       = 4'h8;
   localparam logic [6:0] OWN_ADDR_RST  = 7'h00;
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   typedef struct packed {
      logic busOcc;
      logic rxOvr;
      logic txUndN;
      logic slvAddr;
   } isf_flags_type;
   localparam isf_flags_type FLAGS_RST = '{busOcc: 1'b0, rxOvr: 1'b0, txUndN: 1'b1,
                                           slvAddr: 1'b0};
endpackage

// ---- test/isf_bus_peer.sv ----
// Behavioural model of another device driving the two-wire bus.
`timescale 1ns/100ps
module isf_bus_peer
   import isf_pkg::*;
(
   input  wire logic clk_sys,
   output logic      sclLine,
   output logic      sdaLine
);
   localparam int PHASE = 4;
   initial begin
      sclLine = 1'b1;
      sdaLine = 1'b1;
   end
   // Each line state is held for several module clocks so the synchroniser sees it.
   task automatic setLines(input logic c, input logic d);
      @(posedge clk_sys);
      sclLine <= c;
      sdaLine <= d;
      repeat (PHASE - 1) @(posedge clk_sys);
   endtask
   // A START drops data while the clock is high; it also serves as a repeated START.
   task automatic busStart();
      setLines(1'b0, 1'b1);
      setLines(1'b1, 1'b1);
      setLines(1'b1, 1'b0);
      setLines(1'b0, 1'b0);
   endtask
   // A STOP raises data while the clock is high, then both lines stay at the pull-up level.
   task automatic busStop();
      setLines(1'b0, 1'b0);
      setLines(1'b1, 1'b0);
      setLines(1'b1, 1'b1);
   endtask
   // Eight bits go out most significant first, then a ninth clock with data released.
   task automatic busByte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         setLines(1'b0, b[i]);
         setLines(1'b1, b[i]);
      end
      setLines(1'b0, 1'b1);
      setLines(1'b1, 1'b1);
      setLines(1'b0, 1'b1);
   endtask
endmodule // isf_bus_peer

// ---- test/testbench.sv ----
// Self-checking testbench of the two-wire status-flag block.
`timescale 1ns/100ps
module testbench
   import isf_pkg::*;
;
   logic        clk_sys   = 1'b0;
   logic        reset_n   = 1'b0;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [31:0] paddr     = 32'h0;
   logic [31:0] pwdata    = 32'h0;
   logic        txLoadReq = 1'b0;
   logic [31:0] prdata;
   logic [7:0]  txShiftData;
   logic        pready, pslverr, sclLine, sdaLine, genStart, genRestart, irq;
   logic [31:0] rdData;
   logic        rdErr;
   int          miscompares = 0;
   int          numChecks   = 0;
   int          startCnt    = 0;
   int          restartCnt  = 0;

   isf_status_flags uut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sclIn(sclLine), .sdaIn(sdaLine), .txLoadReq(txLoadReq),
      .txShiftData(txShiftData), .genStart(genStart), .genRestart(genRestart), .irq(irq));
   isf_bus_peer peer (.clk_sys(clk_sys), .sclLine(sclLine), .sdaLine(sdaLine));

   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (genStart === 1'b1) startCnt++;
      if (genRestart === 1'b1) restartCnt++;
   end

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", numChecks, miscompares);
      if (miscompares == 0 && numChecks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {24'h0, a};
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rdData  = prdata;
      rdErr   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Flags are {busy, overrun, underflow_n, addressed}.
   task automatic stat(input logic [3:0] exp);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("status", rdData & 32'h1e00, {19'h0, exp, 9'h0});
   endtask
   task automatic pulseLoad();
      @(posedge clk_sys);
      txLoadReq <= 1'b1;
      @(posedge clk_sys);
      txLoadReq <= 1'b0;
      @(negedge clk_sys);
   endtask

   task automatic testReset();
      stat(4'b0010);
      apb(1'b0, 8'h1c, 32'h0);
      chk("unmapped error", {31'h0, rdErr}, 32'h1);
      peer.setLines(1'b0, 1'b1);
      stat(4'b1010);
      peer.setLines(1'b1, 1'b1);
      apb(1'b1, OFS_STATUS, 32'h1000);
      stat(4'b0010);
   endtask
   task automatic testRx();
      apb(1'b1, OFS_EVEN, 32'h1);
      apb(1'b1, OFS_CTRL, 32'h2a01);
      peer.busStart();
      stat(4'b1010);
      chk("irq on start", {31'h0, irq}, 32'h1);
      apb(1'b1, OFS_EVCLR, 32'h1f);
      repeat (2) @(negedge clk_sys);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      peer.busByte(8'h54);
      stat(4'b1011);
      peer.busByte(8'ha5);
      peer.busByte(8'h3c);
      stat(4'b1111);
      apb(1'b0, OFS_RXDATA, 32'h0);
      chk("held byte", rdData & 32'hff, 32'ha5);
      stat(4'b1011);
      apb(1'b0, OFS_RXDATA, 32'h0);
      chk("pending byte", rdData & 32'hff, 32'h3c);
      peer.busStop();
      stat(4'b0010);
   endtask
   task automatic testGenCall();
      apb(1'b1, OFS_EVEN, 32'h0);
      peer.busStart();
      peer.busByte(8'h00);
      stat(4'b1011);
      apb(1'b0, OFS_EVSTAT, 32'h0);
      chk("start event", rdData & 32'h1, 32'h1);
      chk("masked irq", {31'h0, irq}, 32'h0);
      peer.busStart();
      stat(4'b1010);
      apb(1'b1, OFS_STATUS, 32'h1000);
      stat(4'b0010);
      peer.busStop();
      apb(1'b1, OFS_EVCLR, 32'h1f);
   endtask
   task automatic testFree();
      apb(1'b1, OFS_CTRL, 32'h2a05);
      peer.busStart();
      peer.busByte(8'h81);
      stat(4'b1011);
      apb(1'b0, OFS_RXDATA, 32'h0);
      chk("free data", rdData & 32'hff, 32'h81);
      peer.busStop();
   endtask
   task automatic testStartReq();
      apb(1'b1, OFS_CTRL, 32'h2a03);
      repeat (2) @(posedge clk_sys);
      chk("start pulses", startCnt, 1);
      peer.busStart();
      apb(1'b1, OFS_CTRL, 32'h2a03);
      repeat (2) @(posedge clk_sys);
      chk("restart pulses", restartCnt, 1);
      chk("no extra start", startCnt, 1);
      peer.busStop();
   endtask
   task automatic testTx();
      apb(1'b1, OFS_TXDATA, 32'h5a);
      pulseLoad();
      chk("shifter load", {24'h0, txShiftData}, 32'h5a);
      pulseLoad();
      stat(4'b0000);
      chk("shifter kept", {24'h0, txShiftData}, 32'h5a);
      apb(1'b1, OFS_TXDATA, 32'hc3);
      @(negedge clk_sys);
      chk("late load", {24'h0, txShiftData}, 32'hc3);
      stat(4'b0010);
      pulseLoad();
      stat(4'b0000);
      apb(1'b1, OFS_CTRL, 32'h2a00);
      stat(4'b0010);
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      testReset();
      testRx();
      testGenCall();
      testFree();
      testStartReq();
      testTx();
      summarize();
   end
endmodule // testbench

// ---- verilog/isf_status_flags.sv ----
// Status flags of a two-wire bus controller with APB register access.
// Summary of operation
// RULE1: The bus occupied flag is set when a START is seen on the bus, including one we drive.
// RULE2: The bus occupied flag is also set while clock is low and the module is held in reset.
// RULE3: A start request while the bus is occupied produces a repeated START request.
// RULE4: Overrun is flagged when a new byte completes while the holding register is unread.
// RULE5: During overrun the holding register keeps its byte and new bits overwrite the shifter.
// RULE6: Overrun clears on a holding register read, on module reset, or on processor reset.
// RULE7: Underflow is flagged when the shifter wants data and the holding register is stale.
// RULE8: After underflow the next transfer waits for a write and the old byte may be resent.
// RULE9: The active-low underflow flag goes to one on a write, module reset or processor reset.
// RULE10: Addressed-as-slave sets on a match with the own address or on a general call.
// RULE11: In free data format addressed-as-slave sets once the first word is received.
// RULE12: Addressed-as-slave clears on a repeated START or a STOP.
// RULE13: The bus occupied flag clears on STOP, on a write of one, on processor reset, or on module reset while clock is high.
// RULE14: All flags are registered, with bus conditions taken from synchronised lines.
`timescale 1ns/100ps
module isf_status_flags
   import isf_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   input  wire logic        txLoadReq,
   output logic      [7:0]  txShiftData,
   output logic             genStart,
   output logic             genRestart,
   output logic             irq
);
   logic          rstMeta_r, rstN;
   logic          sclMeta_r, sclSync_r, sclPrev_r;
   logic          sdaMeta_r, sdaSync_r, sdaPrev_r;
   logic          run_r, freeFmt_r;
   logic [6:0]    ownAddr_r;
   isf_flags_type flags_r;
   logic [3:0]    bitCnt_r;
   logic          firstByte_r, rxFull_r, rxPend_r;
   logic [7:0]    rxShift_r, rxHold_r, txHold_r;
   logic          txFresh_r, txWait_r;
   logic [EV_W-1:0] evStat_r, evEn_r, evSet;
   logic [31:0]   rdData;
   logic          mapped, wrDone, rdDone, wrCtrl, wrStatus, wrTx, rdRx;
   logic          sclRise, startDet, stopDet, byteDone, dataDone, addrHit;
   logic          ovrSet, undSet, aasSet;
   logic [7:0]    rxNext;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_r <= 1'b0;
         rstN      <= 1'b0;
      end else begin
         rstMeta_r <= 1'b1;
         rstN      <= rstMeta_r;
      end
   end

   // Bus lines pass two stages before any edge logic looks at them.
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         {sclMeta_r, sclSync_r, sclPrev_r} <= 3'h7;
         {sdaMeta_r, sdaSync_r, sdaPrev_r} <= 3'h7;
      end else begin
         {sclMeta_r, sclSync_r, sclPrev_r} <= {sclIn, sclMeta_r, sclSync_r}; // [RULE14]
         {sdaMeta_r, sdaSync_r, sdaPrev_r} <= {sdaIn, sdaMeta_r, sdaSync_r}; // [RULE14]
      end
   end

   assign sclRise  = sclSync_r & ~sclPrev_r;
   assign startDet = sclSync_r & sclPrev_r & sdaPrev_r & ~sdaSync_r;
   assign stopDet  = sclSync_r & sclPrev_r & ~sdaPrev_r & sdaSync_r;
   assign rxNext   = {rxShift_r[6:0], sdaSync_r};
   assign byteDone = run_r & flags_r.busOcc & sclRise & (bitCnt_r == LAST_DATA_BIT);
   assign dataDone = byteDone & (~firstByte_r | freeFmt_r);
   assign addrHit  = (rxNext[7:1] == ownAddr_r) || (rxNext[7:1] == GEN_CALL_ADDR);

   // APB decode; a request completes at the edge where pready is high.
   always_comb begin
      mapped = (paddr[31:8] == 24'h000000) && (paddr[1:0] == 2'h0);
      rdData = 32'h00000000;
      unique case (paddr[7:0])
         OFS_CTRL: begin
            rdData[CTRL_RUN]                  = run_r;
            rdData[CTRL_FREE]                 = freeFmt_r;
            rdData[CTRL_OWN_LSB +: 7]         = ownAddr_r;
         end
         OFS_STATUS: begin
            rdData[ST_BUSY]  = flags_r.busOcc;
            rdData[ST_OVR]   = flags_r.rxOvr;
            rdData[ST_UND_N] = flags_r.txUndN;
            rdData[ST_AAS]   = flags_r.slvAddr;
         end
         OFS_RXDATA: rdData[7:0]      = rxHold_r;
         OFS_TXDATA: rdData[7:0]      = txHold_r;
         OFS_EVSTAT: rdData[EV_W-1:0] = evStat_r;
         OFS_EVCLR:  rdData           = 32'h00000000;
         OFS_EVEN:   rdData[EV_W-1:0] = evEn_r;
         default:    mapped           = 1'b0;
      endcase
   end

   assign wrDone   = psel & penable & pready & pwrite & mapped;
   assign rdDone   = psel & penable & pready & ~pwrite & mapped;
   assign wrCtrl   = wrDone & (paddr[7:0] == OFS_CTRL);
   assign wrStatus = wrDone & (paddr[7:0] == OFS_STATUS);
   assign wrTx     = wrDone & (paddr[7:0] == OFS_TXDATA);
   assign rdRx     = rdDone & (paddr[7:0] == OFS_RXDATA);

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         prdata  <= (psel & penable & ~pready & ~pwrite) ? rdData : 32'h00000000;
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         run_r      <= 1'b0;
         freeFmt_r  <= 1'b0;
         ownAddr_r  <= OWN_ADDR_RST;
         genStart   <= 1'b0;
         genRestart <= 1'b0;
      end else begin
         genStart   <= wrCtrl & pwdata[CTRL_START] & run_r & ~flags_r.busOcc;
         genRestart <= wrCtrl & pwdata[CTRL_START] & run_r & flags_r.busOcc; // [RULE3]
         if (wrCtrl) begin
            run_r     <= pwdata[CTRL_RUN];
            freeFmt_r <= pwdata[CTRL_FREE];
            ownAddr_r <= pwdata[CTRL_OWN_LSB +: 7];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         flags_r.busOcc <= FLAGS_RST.busOcc;
      end else if (!run_r && !sclSync_r) begin
         flags_r.busOcc <= 1'b1; // [RULE2]
      end else if (startDet) begin
         flags_r.busOcc <= 1'b1; // [RULE1]
      end else if (stopDet || !run_r || (wrStatus && pwdata[ST_BUSY])) begin
         flags_r.busOcc <= 1'b0; // [RULE13]
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         bitCnt_r    <= 4'h0;
         firstByte_r <= 1'b0;
         rxShift_r   <= 8'h00;
      end else if (startDet || stopDet || !run_r) begin
         bitCnt_r    <= 4'h0;
         firstByte_r <= startDet;
      end else if (sclRise && flags_r.busOcc) begin
         bitCnt_r <= (bitCnt_r == ACK_BIT) ? 4'h0 : bitCnt_r + 4'h1;
         if (bitCnt_r != ACK_BIT) begin
            rxShift_r <= rxNext; // [RULE5]
         end
         if (byteDone) begin
            firstByte_r <= 1'b0;
         end
      end
   end

   assign ovrSet = dataDone & rxFull_r & ~rdRx;

   // A held byte is released into the holding register by the read that frees it.
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         rxFull_r <= 1'b0;
         rxPend_r <= 1'b0;
         rxHold_r <= 8'h00;
      end else if (!run_r) begin
         rxFull_r <= 1'b0;
         rxPend_r <= 1'b0;
      end else if (dataDone) begin
         if (ovrSet) begin
            rxPend_r <= 1'b1; // [RULE5]
         end else begin
            rxHold_r <= rxNext;
            rxFull_r <= 1'b1;
            rxPend_r <= 1'b0;
         end
      end else if (rdRx) begin
         if (rxPend_r) begin
            rxHold_r <= rxShift_r;
            rxPend_r <= 1'b0;
         end else begin
            rxFull_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         flags_r.rxOvr <= FLAGS_RST.rxOvr;
      end else if (rdRx || !run_r) begin
         flags_r.rxOvr <= 1'b0; // [RULE6]
      end else if (ovrSet) begin
         flags_r.rxOvr <= 1'b1; // [RULE4]
      end
   end

   assign undSet = run_r & txLoadReq & ~txFresh_r & ~wrTx;

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         txHold_r       <= 8'h00;
         txShiftData    <= 8'h00;
         txFresh_r      <= 1'b0;
         txWait_r       <= 1'b0;
         flags_r.txUndN <= FLAGS_RST.txUndN;
      end else if (!run_r) begin
         txFresh_r      <= 1'b0;
         txWait_r       <= 1'b0;
         flags_r.txUndN <= 1'b1; // [RULE9]
         if (wrTx) begin
            txHold_r <= pwdata[7:0];
         end
      end else if (wrTx) begin
         txHold_r       <= pwdata[7:0];
         flags_r.txUndN <= 1'b1; // [RULE9]
         if (txWait_r || txLoadReq) begin
            txShiftData <= pwdata[7:0]; // [RULE8]
            txWait_r    <= 1'b0;
            txFresh_r   <= 1'b0;
         end else begin
            txFresh_r <= 1'b1;
         end
      end else if (txLoadReq) begin
         if (txFresh_r) begin
            txShiftData <= txHold_r;
            txFresh_r   <= 1'b0;
         end else begin
            flags_r.txUndN <= 1'b0; // [RULE7]
            txWait_r       <= 1'b1; // [RULE8]
         end
      end
   end

   assign aasSet = byteDone & firstByte_r & (freeFmt_r | addrHit);

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         flags_r.slvAddr <= FLAGS_RST.slvAddr;
      end else if (startDet || stopDet || !run_r) begin
         flags_r.slvAddr <= 1'b0; // [RULE12]
      end else if (aasSet) begin
         flags_r.slvAddr <= 1'b1; // [RULE10] [RULE11]
      end
   end

   assign evSet = {aasSet, undSet, ovrSet, stopDet, startDet};

   // A new event wins over a clear written in the same cycle.
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         evStat_r <= '0;
         evEn_r   <= '0;
         irq      <= 1'b0;
      end else begin
         evStat_r <= (evStat_r & ~((wrDone && paddr[7:0] == OFS_EVCLR) ?
                     pwdata[EV_W-1:0] : '0)) | evSet;
         if (wrDone && paddr[7:0] == OFS_EVEN) begin
            evEn_r <= pwdata[EV_W-1:0];
         end
         irq <= |(evStat_r & evEn_r);
      end
   end

   busy_start_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE1]
      startDet |=> flags_r.busOcc) else $error("Bus flag not set after START.");
   busy_held_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE2]
      (!run_r && !sclSync_r) |=> flags_r.busOcc) else $error("Bus flag low in reset.");
   restart_req_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE3]
      (wrCtrl && pwdata[CTRL_START] && run_r && flags_r.busOcc) |=> (genRestart && !genStart))
      else $error("Repeated START not requested.");
   overrun_set_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE4]
      ovrSet && run_r |=> flags_r.rxOvr ##0 $stable(rxHold_r))
      else $error("Overrun not flagged.");
   hold_keep_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE5]
      (rxPend_r && !rdRx && run_r) |=> $stable(rxHold_r)) else $error("Held byte replaced.");
   overrun_clr_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE6]
      (rdRx || !run_r) |=> !flags_r.rxOvr) else $error("Overrun not cleared.");
   underflow_set_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE7]
      undSet |=> !flags_r.txUndN ##1 (flags_r.txUndN || txWait_r))
      else $error("Underflow not flagged.");
   tx_stall_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE8]
      (txWait_r && !wrTx) |=> $stable(txShiftData)) else $error("Transfer during underflow.");
   underflow_end_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE9]
      (wrTx || !run_r) |=> flags_r.txUndN) else $error("Underflow flag not restored.");
   slave_hit_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE10]
      (byteDone && firstByte_r && addrHit) |=> flags_r.slvAddr)
      else $error("Address match missed.");
   free_fmt_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE11]
      (byteDone && firstByte_r && freeFmt_r) |=> flags_r.slvAddr)
      else $error("Free format word missed.");
   slave_clr_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE12]
      (startDet || stopDet) |=> !flags_r.slvAddr) else $error("Slave flag not cleared.");
   busy_stop_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE13]
      (stopDet && run_r) |=> !flags_r.busOcc) else $error("Bus flag not cleared on STOP.");
   line_sync_a: assert property (@(posedge clk_sys) disable iff (!rstN) // [RULE14]
      startDet |-> ($past(sdaIn, 2) == 1'b0)) else $error("START from unsynchronised line.");
endmodule // isf_status_flags
